// [pkg/otm_pkg.sv]
// Constants, register map and types of the overflow timer
package otm_pkg;
	localparam int OTM_ADDR_W = 4;
	localparam logic [OTM_ADDR_W-1:0] OTM_OFS_CONTROL = 4'h4;
	localparam logic [OTM_ADDR_W-1:0] OTM_OFS_COUNT = 4'h8;
	localparam logic [OTM_ADDR_W-1:0] OTM_OFS_IFLAGS = 4'hc;
	localparam logic [OTM_ADDR_W-1:0] OTM_OFS_ICTRL = 4'h0;
	localparam int OTM_CTL_FORCE = 7;
	localparam int OTM_CTL_MODE_HI = 4;
	localparam int OTM_CTL_MODE_LO = 3;
	localparam int OTM_CTL_CS_HI = 2;
	localparam int OTM_INT_OVF = 0;
	localparam logic [7:0] OTM_CONTROL_RESET = 8'h00;
	localparam logic [7:0] OTM_CONTROL_RMASK = 8'h1f;
	localparam logic [7:0] OTM_COUNT_RESET = 8'h00;
	localparam logic OTM_LINE_RESET = 1'b0;
	localparam int OTM_PRESC_W = 10;
	localparam int OTM_TAP_64 = 5;
	localparam int OTM_TAP_256 = 7;
	localparam int OTM_TAP_1024 = 9;
	typedef enum logic [2:0] {
		OTM_CS_STOP = 3'h0,
		OTM_CS_CORE = 3'h1,
		OTM_CS_MOD = 3'h2,
		OTM_CS_DIV64 = 3'h3,
		OTM_CS_DIV256 = 3'h4,
		OTM_CS_DIV1024 = 3'h5,
		OTM_CS_EXT_FALL = 3'h6,
		OTM_CS_EXT_RISE = 3'h7
	} otm_cs_t;
	typedef enum logic [1:0] {
		OTM_OOM_NONE = 2'h0,
		OTM_OOM_TOGGLE = 2'h1,
		OTM_OOM_CLEAR = 2'h2,
		OTM_OOM_SET = 2'h3
	} otm_oom_t;
endpackage

// [core/otm_prescaler.sv]
// Free-running prescaler with one-cycle tap enables
`timescale 1ns/1ns
module otm_prescaler
	import otm_pkg::*;
#(
	parameter int WIDTH = OTM_PRESC_W
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick_64,
	output logic tick_256,
	output logic tick_1024
);
	logic [WIDTH-1:0] presc_reg;
	logic [WIDTH-1:0] presc_next;

	// A tap fires while it and the bits below it are all ones, the cycle before they wrap to zero
	function automatic logic tap_hit(input logic [WIDTH-1:0] v, input int top);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i <= top; i++) begin
			hit = hit & v[i];
		end
		return hit;
	endfunction

	always_comb begin
		presc_next = presc_reg + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_next;
		end
	end

	assign tick_64 = tap_hit(presc_reg, OTM_TAP_64);
	assign tick_256 = tap_hit(presc_reg, OTM_TAP_256);
	assign tick_1024 = tap_hit(presc_reg, OTM_TAP_1024);
endmodule

// [core/otm_timer.sv]
// Overflow timer: counter, clock select, output action, Avalon-MM slave
`timescale 1ns/1ns
module otm_timer
	import otm_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [OTM_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic modulator_tick,
	input wire logic external_count_pin,
	output logic high_current_output_line,
	output logic irq
);
	logic tick_64;
	logic tick_256;
	logic tick_1024;

	otm_prescaler #(.WIDTH(OTM_PRESC_W)) u_presc (
		.clk(clk),
		.rst(rst),
		.tick_64(tick_64),
		.tick_256(tick_256),
		.tick_1024(tick_1024)
	);

	// Bus handshake: one wait cycle, answer in the second
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Register state
	logic [2:0] cs_reg;
	logic [2:0] cs_next;
	logic [1:0] oom_reg;
	logic [1:0] oom_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic ovf_flag_reg;
	logic ovf_flag_next;
	logic ovf_en_reg;
	logic ovf_en_next;
	logic line_reg;
	logic line_next;
	logic irq_reg;
	logic irq_next;

	// Pin synchroniser and edge history
	logic pin_s1_reg;
	logic pin_s1_next;
	logic pin_s2_reg;
	logic pin_s2_next;
	logic pin_s3_reg;
	logic pin_s3_next;
	logic pin_rise;
	logic pin_fall;

	// Waitrequest has a flop of its own
	logic wait_reg;
	logic wait_next;

	// Register write strobes
	logic lane0_wr;
	logic ctl_wr;
	logic cnt_wr;
	logic flags_wr;
	logic ien_wr;

	logic access;
	logic wr_fire;
	logic count_tick;
	logic overflow;
	logic force_ovf;
	logic act;
	logic [31:0] rd_mux;

	function automatic logic hit(input logic [OTM_ADDR_W-1:0] a, input logic [OTM_ADDR_W-1:0] o);
		return a == o;
	endfunction

	assign access = avs_read | avs_write;
	assign wr_fire = avs_write & ack_reg;

	// Byte lanes above 0 carry no register bits
	assign lane0_wr = wr_fire & avs_byteenable[0];
	assign ctl_wr = lane0_wr & hit(avs_address, OTM_OFS_CONTROL);
	assign cnt_wr = lane0_wr & hit(avs_address, OTM_OFS_COUNT);
	assign flags_wr = lane0_wr & hit(avs_address, OTM_OFS_IFLAGS);
	assign ien_wr = lane0_wr & hit(avs_address, OTM_OFS_ICTRL);

	// Pin is read as a level even when driven by this chip as an output
	always_comb begin
		pin_s1_next = external_count_pin;
		pin_s2_next = pin_s1_reg;
		pin_s3_next = pin_s2_reg;
	end

	// Reset level matches an idle low pin, so no false edge follows reset
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end else begin
			pin_s1_reg <= pin_s1_next;
			pin_s2_reg <= pin_s2_next;
			pin_s3_reg <= pin_s3_next;
		end
	end

	// Only the settled stages feed the edge detector
	assign pin_rise = ~pin_s3_reg & pin_s2_reg;
	assign pin_fall = pin_s3_reg & ~pin_s2_reg;

	// Edges narrower than one clock would be missed by the sampler
	always_comb begin
		unique case (otm_cs_t'(cs_reg))
			OTM_CS_STOP: count_tick = 1'b0;
			OTM_CS_CORE: count_tick = 1'b1;
			OTM_CS_MOD: count_tick = modulator_tick;
			OTM_CS_DIV64: count_tick = tick_64;
			OTM_CS_DIV256: count_tick = tick_256;
			OTM_CS_DIV1024: count_tick = tick_1024;
			OTM_CS_EXT_FALL: count_tick = pin_fall;
			OTM_CS_EXT_RISE: count_tick = pin_rise;
		endcase
	end

	// A counter write this cycle wins over a count tick
	assign overflow = count_tick && (cnt_reg == {CNT_W{1'b1}})
		&& !(wr_fire && hit(avs_address, OTM_OFS_COUNT) && avs_byteenable[0]);
	assign force_ovf = wr_fire && hit(avs_address, OTM_OFS_CONTROL) && avs_byteenable[0]
		&& avs_writedata[OTM_CTL_FORCE];
	assign act = overflow | force_ovf;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(avs_address, OTM_OFS_CONTROL)) begin
			rd_mux = {24'h00_0000, 3'h0, oom_reg, cs_reg};
		end else if (hit(avs_address, OTM_OFS_COUNT)) begin
			rd_mux = {{(32-CNT_W){1'b0}}, cnt_reg};
		end else if (hit(avs_address, OTM_OFS_IFLAGS)) begin
			rd_mux = {31'h0000_0000, ovf_flag_reg};
		end else if (hit(avs_address, OTM_OFS_ICTRL)) begin
			rd_mux = {31'h0000_0000, ovf_en_reg};
		end
	end

	always_comb begin
		ack_next = access & ~ack_reg;
		// Waitrequest low only in the acknowledge cycle
		wait_next = ~ack_next;
		rdata_next = rdata_reg;
		// Snapshot taken as the request is first seen
		if (avs_read && !ack_reg) begin
			rdata_next = rd_mux;
		end
	end

	// Waitrequest high in reset so no access is taken too early
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Control fields; the force bit is a strobe, never stored
	// Bits 6 and 5 are neither stored nor returned
	always_comb begin
		cs_next = cs_reg;
		oom_next = oom_reg;
		if (ctl_wr) begin
			cs_next = avs_writedata[OTM_CTL_CS_HI:0];
			oom_next = avs_writedata[OTM_CTL_MODE_HI:OTM_CTL_MODE_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_reg <= OTM_CONTROL_RESET[OTM_CTL_CS_HI:0];
			oom_reg <= OTM_CONTROL_RESET[OTM_CTL_MODE_HI:OTM_CTL_MODE_LO];
		end else begin
			cs_reg <= cs_next;
			oom_reg <= oom_next;
		end
	end

	// Counter: a software write replaces the tick of the same cycle
	always_comb begin
		cnt_next = cnt_reg;
		if (count_tick) begin
			cnt_next = cnt_reg + 1'b1;
		end
		if (cnt_wr) begin
			cnt_next = avs_writedata[CNT_W-1:0];
		end
	end

	// Reset leaves the counter at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= OTM_COUNT_RESET[CNT_W-1:0];
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Interrupt flag and enable; irq follows the next values
	always_comb begin
		ovf_flag_next = ovf_flag_reg;
		ovf_en_next = ovf_en_reg;
		if (flags_wr && avs_writedata[OTM_INT_OVF]) begin
			ovf_flag_next = 1'b0;
		end
		if (ien_wr) begin
			ovf_en_next = avs_writedata[OTM_INT_OVF];
		end
		// Set wins over a same-cycle clear; forces never set it
		if (overflow) begin
			ovf_flag_next = 1'b1;
		end
		// Registered level, so the port has no gate behind it
		irq_next = ovf_flag_next & ovf_en_next;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_flag_reg <= 1'b0;
			ovf_en_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ovf_flag_reg <= ovf_flag_next;
			ovf_en_reg <= ovf_en_next;
			irq_reg <= irq_next;
		end
	end

	// Forced and real overflows share one action path
	// Uses the registered mode, so a same-write mode change waits
	always_comb begin
		line_next = line_reg;
		if (act) begin
			unique case (otm_oom_t'(oom_reg))
				OTM_OOM_NONE: line_next = line_reg;
				OTM_OOM_TOGGLE: line_next = ~line_reg;
				OTM_OOM_CLEAR: line_next = 1'b0;
				OTM_OOM_SET: line_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			line_reg <= OTM_LINE_RESET;
		end else begin
			line_reg <= line_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign high_current_output_line = line_reg;
	assign irq = irq_reg;
endmodule

// [bench/otm_timer_monitor.sv]
// Bus timing and output-action checks of the overflow timer
`timescale 1ns/1ns
module otm_timer_monitor
	import otm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [OTM_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic high_current_output_line,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [1:0] mode_reg, mode_next;
	logic ien_reg, ien_next, wr, rd, ctl, frc, ln;
	always_comb begin
		wr = avs_write && !avs_waitrequest && avs_byteenable[0];
		rd = avs_read && !avs_waitrequest;
		ctl = avs_address == OTM_OFS_CONTROL;
		frc = wr && ctl && avs_writedata[OTM_CTL_FORCE];
		ln = high_current_output_line;
		mode_next = wr && ctl ? avs_writedata[OTM_CTL_MODE_HI:OTM_CTL_MODE_LO] : mode_reg;
		ien_next = wr && avs_address == OTM_OFS_ICTRL ? avs_writedata[OTM_INT_OVF] : ien_reg;
	end
	always_ff @(posedge clk) begin
		mode_reg <= rst ? 2'h0 : mode_next;
		ien_reg <= rst ? 1'b0 : ien_next;
	end
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late answer");
	ctl_read_a: assert property (rd && ctl |-> avs_readdata[31:5] == 27'h0)
		else $error("control bits");
	toggle_out_a: assert property (frc && mode_reg == 2'h1 |=> ln != $past(ln))
		else $error("no toggle");
	clear_out_a: assert property (frc && mode_reg == 2'h2 |=> !ln)
		else $error("no clear");
	set_out_a: assert property (frc && mode_reg == 2'h3 |=> ln)
		else $error("no set");
	idle_out_a: assert property (mode_reg == 2'h0 |=> $stable(ln))
		else $error("line moved");
	irq_mask_a: assert property (!ien_reg ##1 !ien_reg |-> !irq)
		else $error("irq unmasked");
	unmapped_a: assert property (rd && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("unmapped data");
endmodule
bind otm_timer otm_timer_monitor u_mon (
	.clk(clk),
	.rst(rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.high_current_output_line(high_current_output_line),
	.irq(irq)
);

// [bench/otm_pin_model.sv]
// Count pin source; spacing is the caller's gap in clocks
`timescale 1ns/1ns
module otm_pin_model (
	input wire logic clk,
	output logic external_count_pin
);
	initial external_count_pin = 1'b0;
	task automatic pulses(input int n, input int gap);
		repeat (n) begin
			@(posedge clk);
			external_count_pin <= 1'b1;
			repeat (gap) @(posedge clk);
			external_count_pin <= 1'b0;
			repeat (gap) @(posedge clk);
		end
		// Room for the pin synchroniser
		repeat (4) @(posedge clk);
	endtask
endmodule

// [bench/tb_top.sv]
// Register-level tests of the overflow timer
`timescale 1ns/1ns
module tb_top
	import otm_pkg::*;
;
	logic clk, rst, rd_en, wr_en, mtick, wreq, line, irq, pin;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [47:0] fv = 48'hff9890888880;
	logic [5:0] fl = 6'b011010;
	int dv [4] = '{2, 64, 256, 1024};
	int n_errors = 0;
	int checks = 0;
	int n;
	otm_timer u_otm_timer (.clk, .rst, .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
		.avs_writedata(wdata), .avs_byteenable(4'h1), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .modulator_tick(mtick), .external_count_pin(pin),
		.high_current_output_line(line), .irq);
	otm_pin_model u_otm_pin_model (.clk, .external_count_pin(pin));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) mtick <= !mtick;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		wr_en <= w;
		rd_en <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic final_report;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		wt(30000);
		n_errors++;
		final_report;
	end
	initial begin
		rst = 1'b1;
		{rd_en, wr_en, addr, wdata, mtick} = '0;
		wt(12);
		rst <= 1'b0;
		for (int i = 0; i < 16; i += 2) begin
			acc(0, 4'(i), 8'h0);
			chk(q, 0);
		end
		acc(1, OTM_OFS_ICTRL, 8'h01);
		for (int i = 5; i >= 0; i--) begin
			acc(1, OTM_OFS_CONTROL, fv[8*i+:8]);
			acc(0, OTM_OFS_CONTROL, 8'h0);
			chk({q[7:0], line}, {fv[8*i+:8] & 8'h1f, fl[i]});
		end
		acc(0, OTM_OFS_IFLAGS, 8'h0);
		chk({q[7:0], irq}, 0);
		acc(1, OTM_OFS_COUNT, 8'hfd);
		acc(1, OTM_OFS_CONTROL, 8'h0f);
		u_otm_pin_model.pulses(3, 2);
		acc(0, OTM_OFS_COUNT, 8'h0);
		chk({q[7:0], irq, line}, 10'h003);
		acc(1, OTM_OFS_IFLAGS, 8'h01);
		acc(1, OTM_OFS_CONTROL, 8'h06);
		u_otm_pin_model.pulses(2, 1);
		acc(0, OTM_OFS_COUNT, 8'h0);
		chk({q[7:0], irq}, 9'h004);
		acc(1, OTM_OFS_ICTRL, 8'h00);
		acc(1, OTM_OFS_COUNT, 8'hf0);
		acc(1, OTM_OFS_CONTROL, 8'h01);
		wt(20);
		acc(1, OTM_OFS_CONTROL, 8'h00);
		acc(0, OTM_OFS_IFLAGS, 8'h0);
		chk({q[7:0], irq, line}, 10'h005);
		acc(1, OTM_OFS_ICTRL, 8'h01);
		wt(2);
		chk(irq, 1);
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 2; k++) begin
				acc(1, OTM_OFS_CONTROL, 8'(i + 2));
				acc(1, OTM_OFS_IFLAGS, 8'h01);
				acc(1, OTM_OFS_COUNT, 8'hff);
				for (n = 0; irq !== 1'b1 && n < dv[i] + 9; n++) wt(1);
			end
			// irq shows one edge after the overflow tick
			chk(n > dv[i] - 15 && n <= dv[i] + 1, 1);
		end
		final_report;
	end
endmodule
